// [logic/charger_fault_event_flags_defines.vh]
`ifndef CHARGER_FAULT_EVENT_FLAGS_DEFINES_VH
`define CHARGER_FAULT_EVENT_FLAGS_DEFINES_VH

// ************************************************************
// register offsets
// ************************************************************
`define EVF_FLAGS1_ADDR 8'h18
`define EVF_FLAGS2_ADDR 8'h19
`define EVF_FLAGS3_ADDR 8'h1a
`define EVF_FLAGS4_ADDR 8'h1b
`define EVF_FLAGS5_ADDR 8'h1c
`define EVF_GATE1_ADDR  8'h1d
`define EVF_GATE2_ADDR  8'h1e

// ************************************************************
// reset values
// ************************************************************
`define EVF_FLAGS_RESET 8'h00
`define EVF_GATE_RESET  8'h00

// ************************************************************
// field layouts
// ************************************************************
// event_flags_2: bits 7,6,5,3,2 implemented, 4 and 1:0 read zero
`define EVF_FLAGS2_IMPL 8'hec
// interrupt_gate_2: gating bits, cleared by register-reset command
`define EVF_GATE2_GATING 8'hec
// interrupt_gate_2: reserved storage bits 1:0, writable, no effect
`define EVF_GATE2_SPARE 8'h03
// interrupt_gate_2 bit 4 is read-only zero
`define EVF_GATE2_WRITABLE 8'hef

// event_flags_3 layout
`define EVF_SWITCH_PAIR1_BIT 1
`define EVF_SWITCH_PAIR2_BIT 0
// event_flags_4 layout
`define EVF_CONV_DONE_BIT 7
// event_flags_5: low four bits flag on either edge of their status
`define EVF_F5_LEVEL_BITS 4

// measurement channels tracked for single-shot completion
`define EVF_CHANNELS 10

`endif

// [logic/charger_fault_event_flags.v]
`timescale 1ns/1ps
`include "charger_fault_event_flags_defines.vh"

module charger_fault_event_flags
(
   // clock and reset
   input  wire        mclk,
   input  wire        rst_n,
   // register port
   input  wire [7:0]  regAddr,
   input  wire        regRead,
   input  wire        regWrite,
   input  wire [7:0]  regWrData,
   output reg  [7:0]  regRdData,
   input  wire        regResetCmd,
   // flags 1 detector pulses, bit order as register
   input  wire [7:0]  protectEvt,
   // flags 2 detector pulses, reserved bits ignored
   input  wire [7:0]  inputEvt,
   // flags 3 source events (bits 7..2) and switch-pair placement levels
   input  wire [5:0]  sourceEvt,
   input  wire [1:0]  switchPairPlaced,
   // conversion tracking
   input  wire        oneShotMode,
   input  wire        convStart,
   input  wire [9:0]  chanDone,
   input  wire [9:0]  chanEnabled,
   // flags 4 remaining pulses, bits 6..0
   input  wire [6:0]  thermalEvt,
   // flags 5 pulses (bits 7..4) and status levels (bits 3..0)
   input  wire [3:0]  converterEvt,
   input  wire [3:0]  converterStatus,
   // gates for flags 3..5 held elsewhere
   input  wire [7:0]  gate3,
   input  wire [7:0]  gate4,
   input  wire [7:0]  gate5,
   // interrupt request pin
   output reg         irq_out_n
);

   // ************************************************************
   // address decode
   // ************************************************************
   function hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         hit = (addr == offset);
      end
   endfunction

   // read view of the seven registers; reserved bits read zero, except gate 2 spare bits 1:0, which read back as stored
   function [7:0] readMux;
      input [7:0]  addr;
      input [39:0] flagBits;
      input [7:0]  g1;
      input [7:0]  g2;
      begin
         case (addr)
            `EVF_FLAGS1_ADDR: readMux = flagBits[7:0];
            `EVF_FLAGS2_ADDR: readMux = flagBits[15:8] & `EVF_FLAGS2_IMPL;
            `EVF_FLAGS3_ADDR: readMux = flagBits[23:16];
            `EVF_FLAGS4_ADDR: readMux = flagBits[31:24];
            `EVF_FLAGS5_ADDR: readMux = flagBits[39:32];
            `EVF_GATE1_ADDR:  readMux = g1;
            `EVF_GATE2_ADDR:  readMux = g2 & `EVF_GATE2_WRITABLE;
            default:          readMux = 8'h00;
         endcase
      end
   endfunction

   // ************************************************************
   // storage
   // ************************************************************
   // five flag registers packed, register 1 in the low byte
   reg  [39:0] flags;
   reg  [7:0]  gate1;
   reg  [7:0]  gate2;
   reg  [9:0]  chanSeen;
   reg  [1:0]  trackState;
   reg  [1:0]  next_trackState;

   wire [39:0] setVec;
   wire [39:0] next_flags;
   wire [5:0]  levelNow;
   wire [5:0]  levelChange;
   wire [9:0]  seenNow;
   wire        allSeen;
   wire        convBusy;
   wire        convComplete;
   wire [1:0]  pairChange;
   wire [3:0]  statusChange;
   wire [39:0] gateVec;
   wire [4:0]  pendByte;
   wire        pending;

   genvar i;

   // ************************************************************
   // change detection
   // ************************************************************
   // previous levels start at zero, so a level already high at
   // reset release registers as a change once
   assign levelNow = {switchPairPlaced, converterStatus};

   // one detector per level bit, each with its own reference flop
   generate
      for (i = 0; i < 6; i = i + 1)
      begin : levelTrack
         reg prevLevel;
         always @(posedge mclk or negedge rst_n)
         begin
            if (!rst_n)
               prevLevel <= 1'b0;
            else
               prevLevel <= levelNow[i];
         end
         assign levelChange[i] = levelNow[i] ^ prevLevel;
      end
   endgenerate

   assign pairChange   = levelChange[5:4];
   assign statusChange = levelChange[3:0];

   // ************************************************************
   // single-shot completion
   // ************************************************************
   // tracker states, one-hot
   localparam [1:0] TRK_IDLE  = 2'b01;
   localparam [1:0] TRK_ARMED = 2'b10;

   assign seenNow  = chanSeen | chanDone;
   // a disabled channel counts as already seen
   assign allSeen  = ((seenNow & chanEnabled) == chanEnabled);
   assign convBusy = (trackState == TRK_ARMED);

   // a start pulse rearms the tracker; done pulses from channels
   // that are disabled are harmless because they are masked here
   assign convComplete = oneShotMode & convBusy & ~convStart & allSeen;

   // a start while armed restarts the collection; only a
   // single-shot completion returns the tracker to idle
   always @*
   begin
      next_trackState = trackState;
      case (trackState)
         TRK_IDLE:
         begin
            if (convStart)
               next_trackState = TRK_ARMED;
         end
         TRK_ARMED:
         begin
            if (convComplete)
               next_trackState = TRK_IDLE;
         end
         default:
            next_trackState = TRK_IDLE;
      endcase
   end

   // done pulses outside a conversion leave no trace
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trackState <= TRK_IDLE;
         chanSeen   <= 10'h000;
      end
      else
      begin
         trackState <= next_trackState;
         if (convStart || convComplete)
            chanSeen <= 10'h000;
         else if (convBusy)
            chanSeen <= seenNow;
      end
   end

   // ************************************************************
   // event set vector, register 1 in the low byte
   // ************************************************************
   assign setVec[7:0]   = protectEvt;
   assign setVec[15:8]  = inputEvt & `EVF_FLAGS2_IMPL;
   assign setVec[23:18] = sourceEvt;
   // pair 1 lands in bit 1 and pair 2 in bit 0, as the levels arrive
   assign setVec[16 + `EVF_SWITCH_PAIR1_BIT] = pairChange[1];
   assign setVec[16 + `EVF_SWITCH_PAIR2_BIT] = pairChange[0];
   assign setVec[31:24] = {convComplete, thermalEvt};
   assign setVec[39:32] = {converterEvt, statusChange};

   // ************************************************************
   // flag registers
   // ************************************************************
   // one clear strobe per register address
   generate
      for (i = 0; i < 5; i = i + 1)
      begin : flagByte
         localparam [31:0] SLOT   = `EVF_FLAGS1_ADDR + i;
         localparam [7:0]  OFFSET = SLOT[7:0];
         wire rdClr;
         assign rdClr = regRead & hit(regAddr, OFFSET);
         // set is or-ed after the clear so a coincident event survives
         assign next_flags[8*i+7:8*i] =
            (flags[8*i+7:8*i] & ~{8{rdClr}}) | setVec[8*i+7:8*i];
      end
   endgenerate

   // only power-on reset and reads clear flags; the command does not
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         flags <= {5{`EVF_FLAGS_RESET}};
      else
         flags <= next_flags;
   end

   // ************************************************************
   // gate registers
   // ************************************************************
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gate1 <= `EVF_GATE_RESET;
         gate2 <= `EVF_GATE_RESET;
      end
      else
      begin
         if (regResetCmd)
            gate1 <= `EVF_GATE_RESET;
         else if (regWrite && hit(regAddr, `EVF_GATE1_ADDR))
            gate1 <= regWrData;

         // spare bits hold across the reset command
         if (regResetCmd)
            gate2 <= gate2 & `EVF_GATE2_SPARE;
         else if (regWrite && hit(regAddr, `EVF_GATE2_ADDR))
            gate2 <= regWrData & `EVF_GATE2_WRITABLE;
      end
   end

   // ************************************************************
   // read data
   // ************************************************************
   // captured at the read edge, the same edge that clears flags,
   // so the host sees the pre-clear value
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         regRdData <= 8'h00;
      else if (regRead)
         regRdData <= readMux(regAddr, flags, gate1, gate2);
   end

   // ************************************************************
   // interrupt output
   // ************************************************************
   // a set gate bit keeps the flag but hides it from the pin
   assign gateVec = {gate5, gate4, gate3,
                     gate2 & `EVF_GATE2_GATING, gate1};

   // one request term per register keeps the or-tree shallow
   generate
      for (i = 0; i < 5; i = i + 1)
      begin : irqTerm
         assign pendByte[i] = |(flags[8*i+7:8*i] & ~gateVec[8*i+7:8*i]);
      end
   endgenerate

   assign pending = |pendByte;

   // registered so the pin cannot glitch while flags and gates
   // change in the same cycle
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         irq_out_n <= 1'b1;
      else
         irq_out_n <= ~pending;
   end

endmodule

// [verif/charger_fault_event_flags_chk.sv]
`timescale 1ns/1ps
// ***
// flag and pin checks
// ***
module charger_fault_event_flags_chk
(
   // clock, reset, register port
   input wire       mclk,
   input wire       rst_n,
   input wire [7:0] regAddr,
   input wire       regRead,
   input wire       regWrite,
   input wire [7:0] regWrData,
   input wire [7:0] regRdData,
   input wire       regResetCmd,
   // events, gates, pin
   input wire [7:0] protectEvt,
   input wire [6:0] thermalEvt,
   input wire [3:0] converterEvt,
   input wire [3:0] converterStatus,
   input wire [7:0] gate4,
   input wire [7:0] gate5,
   input wire       irq_out_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire rdF1 = regRead && regAddr == 8'h18;
   wire calm = rdF1 && protectEvt == 8'h00;
   wire quiet = !regWrite && !regResetCmd;
   wire wrG1 = regWrite && regAddr == 8'h1d && !regResetCmd;
   wire rdG1 = regRead && regAddr == 8'h1d && quiet;
   property p_clr; calm ##1 protectEvt == 8'h00 ##1 calm |=> regRdData == 8'h00; endproperty
   a_clr: assert property (p_clr) else $error("flag kept");
   property p_keep; rdF1 && protectEvt[7] ##2 rdF1 |=> regRdData[7]; endproperty
   a_keep: assert property (p_keep) else $error("event lost");
   property p_res; regRead && regAddr == 8'h19 |=> (regRdData & 8'h13) == 8'h00; endproperty
   a_res: assert property (p_res) else $error("reserved set");
   property p_b4; regRead && regAddr == 8'h1e |=> !regRdData[4]; endproperty
   a_b4: assert property (p_b4) else $error("gate bit 4");
   property p_g1; wrG1 ##1 quiet ##1 rdG1 |=> regRdData == $past(regWrData, 3); endproperty
   a_g1: assert property (p_g1) else $error("gate readback");
   property p_f4; thermalEvt[0] && !gate4[0] ##1 !gate4[0] |=> !irq_out_n; endproperty
   a_f4: assert property (p_f4) else $error("no irq 4");
   property p_f5; converterEvt[3] && !gate5[7] ##1 !gate5[7] |=> !irq_out_n; endproperty
   a_f5: assert property (p_f5) else $error("no irq 5");
   property p_chg; $changed(converterStatus[0]) && !gate5[0] ##1 !gate5[0] |=> !irq_out_n;
   endproperty
   a_chg: assert property (p_chg) else $error("no irq edge");
endmodule
bind charger_fault_event_flags charger_fault_event_flags_chk chk (.mclk(mclk), .rst_n(rst_n),
   .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWrData(regWrData),
   .regRdData(regRdData), .regResetCmd(regResetCmd), .protectEvt(protectEvt),
   .thermalEvt(thermalEvt), .converterEvt(converterEvt), .converterStatus(converterStatus),
   .gate4(gate4), .gate5(gate5), .irq_out_n(irq_out_n));

// [verif/host_model.sv]
`timescale 1ns/1ps
// ***
// host on the register port
// ***
module host_model
(
   // register port
   input  wire       mclk,
   input  wire [7:0] regRdData,
   output reg  [7:0] regAddr = 8'h00,
   output reg        regRead = 1'b0,
   output reg        regWrite = 1'b0,
   output reg  [7:0] regWrData = 8'h00
);
   // entered at a falling edge; idle cycle after each strobe
   task rd(input logic [7:0] a, output logic [7:0] d);
      {regAddr, regRead} = {a, 1'b1};
      @(negedge mclk);
      {regAddr, regRead} = {~a, 1'b0};
      d = regRdData;
      @(negedge mclk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      {regAddr, regWrData, regWrite} = {a, v, 1'b1};
      @(negedge mclk);
      {regAddr, regWrData, regWrite} = {~a, ~v, 1'b0};
      @(negedge mclk);
   endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
// ***
// event flag bench
// ***
module testbench;
   reg          mclk = 1'b0, rst_n, regResetCmd, oneShotMode, convStart;
   reg  [7:0]   ev, gate3, gate4, gate5, q;
   reg  [1:0]   switchPairPlaced;
   reg  [3:0]   converterStatus;
   reg  [9:0]   chanDone, chanEnabled;
   wire [7:0]   regAddr, regWrData, regRdData, protectEvt = ev, inputEvt = ev;
   wire [5:0]   sourceEvt = ev[7:2];
   wire [6:0]   thermalEvt = ev[6:0];
   wire [3:0]   converterEvt = ev[7:4];
   wire         regRead, regWrite, irq_out_n;
   logic [31:0] seed = 32'd70;
   logic [7:0]  acc [0:4];
   int          fail_count = 0, tests_run = 0, i, k;
   charger_fault_event_flags dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
      .regRead(regRead), .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
      .regResetCmd(regResetCmd), .protectEvt(protectEvt), .inputEvt(inputEvt),
      .sourceEvt(sourceEvt), .switchPairPlaced(switchPairPlaced), .oneShotMode(oneShotMode),
      .convStart(convStart), .chanDone(chanDone), .chanEnabled(chanEnabled),
      .thermalEvt(thermalEvt), .converterEvt(converterEvt), .converterStatus(converterStatus),
      .gate3(gate3), .gate4(gate4), .gate5(gate5), .irq_out_n(irq_out_n));
   host_model host (.mclk(mclk), .regRdData(regRdData), .regAddr(regAddr), .regRead(regRead),
      .regWrite(regWrite), .regWrData(regWrData));
   always #10 mclk = ~mclk;
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [7:0] evtBits(input int n, input logic [7:0] v);
      return v & (n == 0 ? 8'hff : n == 1 ? 8'hec : n == 2 ? 8'hfc : n == 3 ? 8'h7f : 8'hf0);
   endfunction
   task wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task expectRd(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, q);
      `CHK(q, e)
   endtask
   // lv[5:4] placement levels, lv[3:0] converter status levels
   task pulse(input logic [7:0] v, input logic [7:0] lv);
      for (k = 0; k < 5; k++)
         acc[k] |= evtBits(k, v);
      acc[2][1:0] |= lv[5:4] ^ switchPairPlaced;
      acc[4][3:0] |= lv[3:0] ^ converterStatus;
      {ev, switchPairPlaced, converterStatus} = {v, lv[5:0]};
      @(negedge mclk);
      ev = 8'h00;
      @(negedge mclk);
   endtask
   task readAll;
      for (k = 0; k < 5; k++)
      begin
         expectRd(8'h18 + 8'(k), acc[k]);
         acc[k] = 8'h00;
      end
   endtask
   initial
   begin
      {rst_n, regResetCmd, oneShotMode, convStart, ev, gate3, gate4, gate5} = 36'h0;
      {switchPairPlaced, converterStatus, chanDone, chanEnabled} = 26'h0;
      for (k = 0; k < 5; k++)
         acc[k] = 8'h00;
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      for (k = 0; k < 8; k++)
         expectRd(8'h18 + 8'(k), 8'h00);
      $display("reset values done");
      for (i = 0; i < 24; i++)
      begin
         pulse(xs(), xs());
         if (i % 4 == 3)
            readAll;
      end
      $display("random events done");
      fork
         pulse(8'h80, {2'b00, switchPairPlaced, converterStatus});
         host.rd(8'h18, q);
      join
      expectRd(8'h18, 8'h80);
      acc[0] = 8'h00;
      readAll;
      $display("read collision done");
      host.wr(8'h1d, 8'hff);
      expectRd(8'h1d, 8'hff);
      host.wr(8'h1e, 8'hff);
      expectRd(8'h1e, 8'hef);
      host.wr(8'h18, 8'hff);
      expectRd(8'h18, 8'h00);
      {gate3, gate4, gate5} = 24'hffffff;
      pulse(8'hff, xs());
      `CHK(irq_out_n, 1'b1)
      regResetCmd = 1'b1;
      @(negedge mclk);
      regResetCmd = 1'b0;
      expectRd(8'h1e, 8'h03);
      expectRd(8'h1d, 8'h00);
      `CHK(irq_out_n, 1'b0)
      readAll;
      `CHK(irq_out_n, 1'b1)
      $display("gate test done");
      {oneShotMode, chanEnabled, convStart} = {1'b1, 10'h201, 1'b1};
      @(negedge mclk);
      {convStart, chanDone} = {1'b0, 10'h001};
      @(negedge mclk);
      chanDone = 10'h000;
      expectRd(8'h1b, 8'h00);
      chanDone = 10'h200;
      @(negedge mclk);
      chanDone = 10'h000;
      expectRd(8'h1b, 8'h80);
      chanDone = 10'h201;
      @(negedge mclk);
      chanDone = 10'h000;
      expectRd(8'h1b, 8'h00);
      $display("conversion test done");
      pulse(8'h01, {2'b00, switchPairPlaced, converterStatus});
      expectRd(8'h18, 8'h01);
      expectRd(8'h18, 8'h00);
      $display("clear on read done");
      wrap_up;
   end
   // whole run is about two hundred cycles; ten times that margin
   initial
   begin
      #40000;
      fail_count++;
      wrap_up;
   end
endmodule
